// ==== usb_port_fault_and_mode_ctrl.sv ====
`timescale 1ns/1ps
// What this block does
// RQ1: four straight peak trips below 2V reset converter
// RQ2: short or RQ1 trip event resets, flags, retries after delay
// RQ3: sense overvoltage stops switching, flags, while it lasts
// RQ4: overtemperature shuts down until cooled fifteen degrees
// RQ5: thermal warning flag set above 145 degrees, register variant only
// RQ6: hold mode keeps power until timer expires
// RQ7: current limit from three-bit setup field, third pin in pin variant
// RQ8: droop compensation from five-bit setup field
// RQ9: pin variant builds droop code from two pins
// RQ10: two-bit field selects modes, role pin low
// RQ11: code 00 path A, code 10 path B
// RQ12: code 01 follows downstream detection activity
// RQ13: code 11 low-current bias, path B closed
// RQ14: role pin high is invalid, path B only
// RQ15: enable or supply low opens both paths
// RQ16: role class change forces a device reset
// RQ17: pin variant picks mode from role pin
// RQ18: host puts port in pass-through before peripheral
// RQ19: fault output held while any fault persists
// RQ20: error bits clear on read, resume if present
// RQ21: enable rise loads startup fields from first pin
// RQ22: reset delay and hold time are cycle parameters
// RQ23: comparator inputs synchronised before fault decisions
module usb_port_fault_and_mode_ctrl
   import usb_port_pkg::*;
#(
   parameter int RESET_DELAY_CYC = RESET_DELAY_CYC_DEF,
   parameter int HOLD_CYC = HOLD_CYC_DEF,
   parameter logic [CD_W-1:0] CD_STARTUP = CD_PASS
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // comparators and converter events
   input wire logic switch_node_peak_trip_i,
   input wire logic switch_cycle_i,
   input wire logic out_below_2v_i,
   input wire logic out_short_i,
   input wire logic neg_current_sense_node_ov_i,
   input wire logic temp_above_175_i,
   input wire logic temp_cooled_i,
   input wire logic temp_above_145_i,
   input wire logic cdp_detect_active_i,
   // pins
   input wire logic high_voltage_enable_pin_i,
   input wire logic logic_supply_i,
   input wire logic role_select_pin_i,
   input wire logic pin_config_variant_i,
   input wire logic [CFG1_W-1:0] first_cfg_resistor_pin_i,
   input wire logic [CFG2_W-1:0] second_cfg_resistor_pin_i,
   input wire logic [ILIM_W+1:0] third_cfg_resistor_pin_i,
   // converter control
   output logic conv_switch_en_o,
   output logic conv_reset_o,
   output logic device_powered_o,
   output logic [ILIM_W-1:0] current_limit_select_o,
   output logic [GAIN_W-1:0] droop_gain_o,
   output logic [CFG1_W-1:0] startup_cfg_o,
   // data switches
   output logic switch_path_a_o,
   output logic switch_path_b_o,
   output logic low_current_bias_o,
   // open-drain fault and alert pins
   output logic fault_pin_o,
   output logic fault_pin_oe_o,
   output logic alert_pin_o,
   output logic alert_pin_oe_o
);

   localparam int SYNC_W = 13 + CFG1_W + CFG2_W + ILIM_W + 2;

   // synchronised copies
   logic peak_trip_s, cycle_s, below_2v_s, short_s, neg_ov_s, hot_s, cooled_s, warm_s, cdp_s;
   logic hv_en_s, supply_s, role_s, pin_variant_s;
   logic [CFG1_W-1:0] cfg1_s;
   logic [CFG2_W-1:0] cfg2_s;
   logic [ILIM_W+1:0] cfg3_s;
   logic [SYNC_W-1:0] sync_vec;

   // registers and state
   logic [CFG1_W-1:0] setup_1;
   logic [GAIN_W-1:0] setup_2_gain;
   logic [CD_W-1:0] setup_3_cd;
   logic [ILIM_W-1:0] setup_4_ilim;
   logic setup_4_hold;
   logic [ERR_W-1:0] error_1;
   logic [ERR_W-1:0] next_error_1;
   logic [ERR_W-1:0] live_err;
   conv_state_e state, next_state;
   logic cycle_q, hv_en_q, therm_hot, hold_active, role_dedicated_q, role_reset;
   logic [2:0] trip_count;
   logic stg_evt, powered, hold_en_eff, reg_variant, fault_live;
   logic next_sw_a, next_sw_b, next_lo_bias, role_dedicated;
   logic retry_busy, retry_done, hold_busy, hold_done;
   logic wb_req, wb_fire;
   logic [31:0] rd_data;

   // every pin and comparator goes through the synchroniser
   input_sync #(.WIDTH(SYNC_W)) u_sync ( // RQ23
      .ref_clk_i(ref_clk_i),
      .arst_n_i(arst_n_i),
      .async_i({switch_node_peak_trip_i, switch_cycle_i, out_below_2v_i, out_short_i,
                neg_current_sense_node_ov_i, temp_above_175_i, temp_cooled_i, temp_above_145_i,
                cdp_detect_active_i, high_voltage_enable_pin_i, logic_supply_i, role_select_pin_i,
                pin_config_variant_i, first_cfg_resistor_pin_i, second_cfg_resistor_pin_i,
                third_cfg_resistor_pin_i}),
      .sync_o(sync_vec)
   );
   assign {peak_trip_s, cycle_s, below_2v_s, short_s, neg_ov_s, hot_s, cooled_s, warm_s, cdp_s,
           hv_en_s, supply_s, role_s, pin_variant_s, cfg1_s, cfg2_s, cfg3_s} = sync_vec;

   // variant and effective settings
   assign reg_variant = !pin_variant_s;
   assign hold_en_eff = reg_variant ? setup_4_hold : cfg3_s[ILIM_W];
   assign powered = hv_en_s | hold_active | (hv_en_q & hold_en_eff); // RQ6

   // consecutive peak-current trips sampled once per switching cycle
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cycle_q <= 1'b0;
         trip_count <= 3'h0;
      end else begin
         cycle_q <= cycle_s;
         if (cycle_s && !cycle_q) begin
            if (!peak_trip_s) begin
               trip_count <= 3'h0;
            end else if (trip_count != LX_TRIP_COUNT) begin
               trip_count <= trip_count + 3'h1;
            end
         end
      end
   end
   assign stg_evt = cycle_s && !cycle_q && peak_trip_s && below_2v_s
                    && (trip_count >= LX_TRIP_COUNT - 3'h1); // RQ1

   // thermal shutdown with hysteresis
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         therm_hot <= 1'b0;
      end else if (hot_s) begin
         therm_hot <= 1'b1; // RQ4
      end else if (cooled_s) begin
         therm_hot <= 1'b0; // RQ4
      end
   end

   // hold timer keeps power after enable falls
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         hv_en_q <= 1'b0;
         hold_active <= 1'b0;
      end else begin
         hv_en_q <= hv_en_s;
         if (hv_en_q && !hv_en_s && hold_en_eff) begin
            hold_active <= 1'b1; // RQ6
         end else if (hold_done || hv_en_s) begin
            hold_active <= 1'b0; // RQ6
         end
      end
   end

   cycle_timer u_hold_timer (
      .ref_clk_i(ref_clk_i),
      .arst_n_i(arst_n_i),
      .load_i(hv_en_q && !hv_en_s && hold_en_eff),
      .cancel_i(hv_en_s),
      .count_i(TIMER_W'(HOLD_CYC)), // RQ22
      .busy_o(hold_busy),
      .done_o(hold_done)
   );

   // converter supervisor next state
   always_comb begin
      next_state = state;
      unique case (state)
         CONV_OFF: begin
            if (powered && !therm_hot) begin
               next_state = CONV_RUN;
            end
         end
         CONV_RUN: begin
            if (!powered) begin
               next_state = CONV_OFF;
            end else if (therm_hot) begin
               next_state = CONV_THERM; // RQ4
            end else if (neg_ov_s) begin
               next_state = CONV_OV; // RQ3
            end else if (short_s || stg_evt || role_reset) begin
               next_state = CONV_RETRY; // RQ2
            end
         end
         CONV_RETRY: begin
            if (!powered) begin
               next_state = CONV_OFF;
            end else if (therm_hot) begin
               next_state = CONV_THERM;
            end else if (neg_ov_s) begin
               next_state = CONV_OV;
            end else if (retry_done) begin
               next_state = CONV_RUN; // RQ2
            end
         end
         CONV_OV: begin
            if (!powered) begin
               next_state = CONV_OFF;
            end else if (therm_hot) begin
               next_state = CONV_THERM;
            end else if (!neg_ov_s) begin
               next_state = CONV_RUN; // RQ3
            end
         end
         CONV_THERM: begin
            if (!powered) begin
               next_state = CONV_OFF;
            end else if (!therm_hot) begin
               next_state = CONV_RUN; // RQ4
            end
         end
      endcase
   end

   cycle_timer u_retry_timer (
      .ref_clk_i(ref_clk_i),
      .arst_n_i(arst_n_i),
      .load_i(state != CONV_RETRY && next_state == CONV_RETRY),
      .cancel_i(next_state != CONV_RETRY),
      .count_i(TIMER_W'(RESET_DELAY_CYC)), // RQ22
      .busy_o(retry_busy),
      .done_o(retry_done)
   );

   // supervisor state and converter outputs
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state <= CONV_OFF;
         conv_switch_en_o <= 1'b0;
         conv_reset_o <= 1'b0;
         device_powered_o <= 1'b0;
      end else begin
         state <= next_state;
         conv_switch_en_o <= (next_state == CONV_RUN) && !neg_ov_s; // RQ3
         conv_reset_o <= (next_state == CONV_RETRY); // RQ1
         device_powered_o <= (next_state != CONV_OFF) && (next_state != CONV_THERM);
      end
   end

   // fault pin follows any present fault
   assign fault_live = short_s || neg_ov_s || therm_hot || (state == CONV_RETRY) || (state == CONV_OV);
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fault_pin_o <= 1'b0;
         fault_pin_oe_o <= 1'b0;
      end else begin
         fault_pin_o <= 1'b0;
         fault_pin_oe_o <= fault_live; // RQ19
      end
   end

   // error flags, set wins over clear-on-read
   assign live_err = {warm_s && reg_variant, therm_hot, neg_ov_s, short_s || stg_evt}; // RQ5
   always_comb begin
      next_error_1 = error_1 | live_err;
      if (wb_fire && !wb_we_i && wb_adr_i == ADDR_ERROR_1) begin
         next_error_1 = live_err; // RQ20
      end
   end
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         error_1 <= ERR_RST;
         alert_pin_o <= 1'b0;
         alert_pin_oe_o <= 1'b0;
      end else begin
         error_1 <= next_error_1;
         alert_pin_o <= 1'b0;
         alert_pin_oe_o <= |next_error_1; // RQ20
      end
   end

   // data switch mode decode
   always_comb begin
      next_sw_a = 1'b0;
      next_sw_b = 1'b0;
      next_lo_bias = 1'b0;
      if (!hv_en_s || !supply_s) begin
         next_sw_a = 1'b0; // RQ15
         next_sw_b = 1'b0;
      end else if (!reg_variant) begin
         next_sw_a = !role_s; // RQ17
         next_sw_b = role_s;
      end else if (role_s) begin
         next_sw_b = 1'b1; // RQ14
      end else begin
         unique case (setup_3_cd) // RQ10
            CD_PASS: next_sw_a = 1'b1; // RQ11
            CD_AUTO: begin
               next_sw_a = !cdp_s; // RQ12
               next_sw_b = cdp_s;
            end
            CD_DCP_HI: next_sw_b = 1'b1; // RQ11
            CD_DCP_LO: begin
               next_sw_b = 1'b1; // RQ13
               next_lo_bias = 1'b1;
            end
         endcase
      end
   end
   assign role_dedicated = reg_variant ? (role_s || setup_3_cd[1]) : role_s;

   // switch outputs and role-change reset
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         switch_path_a_o <= 1'b0;
         switch_path_b_o <= 1'b0;
         low_current_bias_o <= 1'b0;
         role_dedicated_q <= 1'b0;
         role_reset <= 1'b0;
      end else begin
         switch_path_a_o <= next_sw_a;
         switch_path_b_o <= next_sw_b;
         low_current_bias_o <= next_lo_bias;
         role_dedicated_q <= role_dedicated;
         role_reset <= (state != CONV_OFF) && (role_dedicated != role_dedicated_q); // RQ16
      end
   end

   // wishbone handshake, write and clear act on the acked edge
   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wb_fire = wb_cyc_i && wb_stb_i && wb_ack_o;

   // read mux, unmapped reads zero
   always_comb begin
      rd_data = '0;
      unique case (wb_adr_i)
         ADDR_SETUP_1: rd_data[CFG1_W-1:0] = setup_1;
         ADDR_SETUP_2: rd_data[GAIN_W-1:0] = setup_2_gain;
         ADDR_SETUP_3: rd_data[CD_W-1:0] = setup_3_cd;
         ADDR_SETUP_4: rd_data[SETUP4_HOLD_BIT:0] = {setup_4_hold, setup_4_ilim};
         ADDR_ERROR_1: rd_data[ERR_W-1:0] = next_error_1; // RQ20
         ADDR_STATUS: rd_data[8:0] = {hold_active, fault_live, switch_path_b_o, switch_path_a_o, state};
         default: rd_data = '0;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req) begin
            wb_dat_o <= wb_we_i ? 32'h0 : rd_data;
         end
      end
   end

   // setup registers, startup load on enable rise
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         setup_1 <= SETUP_1_RST;
         setup_2_gain <= GAIN_RST;
         setup_3_cd <= CD_STARTUP;
         setup_4_ilim <= ILIM_RST;
         setup_4_hold <= 1'b0;
      end else if (hv_en_s && !hv_en_q && !hold_active) begin
         setup_1 <= cfg1_s; // RQ21
         setup_3_cd <= CD_STARTUP;
      end else if (wb_fire && wb_we_i && wb_sel_i[0]) begin
         unique case (wb_adr_i)
            ADDR_SETUP_1: setup_1 <= wb_dat_i[CFG1_W-1:0];
            ADDR_SETUP_2: setup_2_gain <= wb_dat_i[GAIN_W-1:0]; // RQ8
            ADDR_SETUP_3: setup_3_cd <= wb_dat_i[CD_W-1:0];
            ADDR_SETUP_4: begin
               setup_4_ilim <= wb_dat_i[ILIM_W-1:0]; // RQ7
               setup_4_hold <= wb_dat_i[SETUP4_HOLD_BIT];
            end
            default: ;
         endcase
      end
   end

   // analog settings by variant
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         current_limit_select_o <= ILIM_RST;
         droop_gain_o <= GAIN_RST;
         startup_cfg_o <= SETUP_1_RST;
      end else begin
         current_limit_select_o <= reg_variant ? setup_4_ilim : cfg3_s[ILIM_W-1:0]; // RQ7
         droop_gain_o <= reg_variant ? setup_2_gain : {cfg3_s[ILIM_W+1], cfg2_s}; // RQ9
         startup_cfg_o <= setup_1;
      end
   end

   // checks
   a_sw_off_en: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // RQ15
      (!hv_en_s || !supply_s) |=> (!switch_path_a_o && !switch_path_b_o))
      else $error("switch path closed with enable or supply low");
   a_role_invalid: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // RQ14
      (reg_variant && hv_en_s && supply_s && role_s) |=> (!switch_path_a_o && switch_path_b_o))
      else $error("role pin high not decoded as invalid mode");
   a_cd_pass: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // RQ11
      (reg_variant && hv_en_s && supply_s && !role_s && setup_3_cd == CD_PASS)
      |=> (switch_path_a_o && !switch_path_b_o))
      else $error("pass-through did not close path A only");
   a_cd_auto: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // RQ12
      (reg_variant && hv_en_s && supply_s && !role_s && setup_3_cd == CD_AUTO)
      |=> (switch_path_b_o == $past(cdp_s)) && (switch_path_a_o != switch_path_b_o))
      else $error("auto mode path does not follow detection");
   a_cd_low_bias: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // RQ13
      (reg_variant && hv_en_s && supply_s && !role_s && setup_3_cd == CD_DCP_LO)
      |=> (low_current_bias_o && switch_path_b_o && !switch_path_a_o))
      else $error("low-current bias mode wrong");
   a_stg_retry: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // RQ1
      (state == CONV_RUN && stg_evt && powered && !therm_hot && !neg_ov_s)
      |=> (conv_reset_o && state == CONV_RETRY) ##1 fault_pin_oe_o)
      else $error("short not followed by converter reset");
   a_short_fault: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // RQ2
      (short_s && state == CONV_RUN && powered && !therm_hot && !neg_ov_s)
      |=> (conv_reset_o && fault_pin_oe_o && error_1[ERR_SHORT]))
      else $error("short did not reset and flag");
   a_ov_stop: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // RQ3
      neg_ov_s |=> (!conv_switch_en_o && fault_pin_oe_o && error_1[ERR_OV]))
      else $error("overvoltage did not stop switching");
   a_therm_off: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // RQ4
      $rose(therm_hot) |-> ##1 !conv_switch_en_o [*2])
      else $error("converter switching while overheated");
   a_warn_flag: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // RQ5
      (warm_s && reg_variant) |=> error_1[ERR_TWARN])
      else $error("thermal warning flag not set");
   a_hold_start: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // RQ6
      ($fell(hv_en_s) && hold_en_eff && state == CONV_RUN) |=> (hold_active && hold_busy))
      else $error("hold timer did not start");
   a_retry_hold: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // RQ22
      $rose(conv_reset_o) |-> retry_busy)
      else $error("retry entered without reset delay");

endmodule

// ==== usb_port_pkg.sv ====
package usb_port_pkg;

   // clock and timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int RESET_DELAY_MS = 16;
   localparam int RESET_DELAY_CYC_DEF = (RESET_DELAY_MS * 1000000) / CLK_PERIOD_NS;
   localparam int HOLD_CYC_DEF = 1000000;
   localparam int TIMER_W = 32;

   // register byte offsets
   localparam logic [7:0] ADDR_SETUP_1 = 8'h00;
   localparam logic [7:0] ADDR_SETUP_2 = 8'h04;
   localparam logic [7:0] ADDR_SETUP_3 = 8'h08;
   localparam logic [7:0] ADDR_SETUP_4 = 8'h0C;
   localparam logic [7:0] ADDR_ERROR_1 = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;

   // field widths and positions
   localparam int GAIN_W = 5;
   localparam int ILIM_W = 3;
   localparam int CD_W = 2;
   localparam int CFG1_W = 2;
   localparam int CFG2_W = 4;
   localparam int ERR_W = 4;
   localparam int SETUP4_HOLD_BIT = 3;
   localparam int ERR_SHORT = 0;
   localparam int ERR_OV = 1;
   localparam int ERR_TSHUT = 2;
   localparam int ERR_TWARN = 3;

   // reset values
   localparam logic [CFG1_W-1:0] SETUP_1_RST = 2'h0;
   localparam logic [GAIN_W-1:0] GAIN_RST = 5'h00;
   localparam logic [ILIM_W-1:0] ILIM_RST = 3'h0;
   localparam logic [ERR_W-1:0] ERR_RST = 4'h0;

   // consecutive peak-current trips before a short is declared
   localparam logic [2:0] LX_TRIP_COUNT = 3'h4;

   // charge-detection field codes
   localparam logic [CD_W-1:0] CD_PASS = 2'h0;
   localparam logic [CD_W-1:0] CD_AUTO = 2'h1;
   localparam logic [CD_W-1:0] CD_DCP_HI = 2'h2;
   localparam logic [CD_W-1:0] CD_DCP_LO = 2'h3;

   // converter supervisor states
   typedef enum logic [4:0] {
      CONV_OFF = 5'b00001,
      CONV_RUN = 5'b00010,
      CONV_RETRY = 5'b00100,
      CONV_OV = 5'b01000,
      CONV_THERM = 5'b10000
   } conv_state_e;

endpackage

// ==== input_sync.sv ====
`timescale 1ns/1ps
module input_sync
   import usb_port_pkg::*;
#(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   // asynchronous inputs and their clean copies
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   // three-flop chain, a change counts once the last two agree
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
         sync_o <= '0;
      end else begin
         stage1 <= async_i;
         stage2 <= stage1;
         stage3 <= stage2;
         for (int i = 0; i < WIDTH; i++) begin
            if (stage2[i] == stage3[i]) begin
               sync_o[i] <= stage3[i];
            end
         end
      end
   end

endmodule

// ==== cycle_timer.sv ====
`timescale 1ns/1ps
module cycle_timer
   import usb_port_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   // control
   input wire logic load_i,
   input wire logic cancel_i,
   input wire logic [TIMER_W-1:0] count_i,
   // status
   output logic busy_o,
   output logic done_o
);

   logic [TIMER_W-1:0] remain;

   // down counter, done is a one-cycle pulse at expiry
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         remain <= '0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (load_i) begin
            remain <= count_i;
            busy_o <= 1'b1;
         end else if (cancel_i) begin
            busy_o <= 1'b0;
         end else if (busy_o) begin
            if (remain <= TIMER_W'(1)) begin
               busy_o <= 1'b0;
               done_o <= 1'b1;
            end
            remain <= remain - TIMER_W'(1);
         end
      end
   end

endmodule

// ==== far_side_model.sv ====
`timescale 1ns/1ps
module far_side_model (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   // bench controls
   input wire logic run_i,
   input wire logic role_hi_i,
   // lines toward the block
   output logic switch_cycle_o,
   output logic role_select_pin_o
);
   logic [1:0] div;
   // switching marker, still outside runs
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         div <= 2'h0;
         switch_cycle_o <= 1'b0;
      end else if (!run_i) begin
         div <= 2'h0;
         switch_cycle_o <= 1'b0;
      end else begin
         div <= div + 2'h1;
         if (div == 2'h3) begin
            switch_cycle_o <= ~switch_cycle_o;
         end
      end
   end
   // role pin driven straight from the bench role_hi_i control
   assign role_select_pin_o = role_hi_i;
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
   import usb_port_pkg::*;
   logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, trip = 0, run = 0, below = 0, shrt = 0, ov = 0;
   logic t175 = 0, cool = 0, t145 = 0, cdp = 0, hv = 1, sup = 1, role_hi = 0, pinv = 0, scyc, role;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, q, rdat;
   logic [3:0] cfg2 = 4'h0;
   logic [4:0] cfg3 = 5'h00, gain;
   logic [2:0] ilim;
   logic ack, sw, crst, pwr, pa, pb, foe, lob, aoe, fpo, apo;
   logic [1:0] scfg;
   // rows: hv, supply, role, mode[1:0], detect, path a, path b
   logic [7:0] rows [8] = '{8'hC2, 8'hCA, 8'hCD, 8'hD1, 8'hD9, 8'hE1, 8'h40, 8'h80};
   int err_count = 0, total_checks = 0;
   always #2.5 clk = ~clk;
   far_side_model fsm (.ref_clk_i(clk), .arst_n_i(rst_n), .run_i(run), .role_hi_i(role_hi),
      .switch_cycle_o(scyc), .role_select_pin_o(role));
   usb_port_fault_and_mode_ctrl #(.RESET_DELAY_CYC(20), .HOLD_CYC(30)) dut (.ref_clk_i(clk), .arst_n_i(rst_n),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .switch_node_peak_trip_i(trip), .switch_cycle_i(scyc),
      .out_below_2v_i(below), .out_short_i(shrt), .neg_current_sense_node_ov_i(ov), .temp_above_175_i(t175),
      .temp_cooled_i(cool), .temp_above_145_i(t145), .cdp_detect_active_i(cdp), .high_voltage_enable_pin_i(hv),
      .logic_supply_i(sup), .role_select_pin_i(role), .pin_config_variant_i(pinv),
      .first_cfg_resistor_pin_i(2'h1), .second_cfg_resistor_pin_i(cfg2), .third_cfg_resistor_pin_i(cfg3),
      .conv_switch_en_o(sw), .conv_reset_o(crst), .device_powered_o(pwr), .current_limit_select_o(ilim),
      .droop_gain_o(gain), .startup_cfg_o(scfg), .switch_path_a_o(pa), .switch_path_b_o(pb),
      .low_current_bias_o(lob), .fault_pin_o(fpo), .fault_pin_oe_o(foe), .alert_pin_o(apo), .alert_pin_oe_o(aoe));
   task tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task final_report;
      if (err_count == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one classic bus cycle, bounded wait for ack
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = rdat;
      cyc <= 0;
      stb <= 0;
      if (n >= 50) begin
         err_count++;
         final_report();
      end
   endtask
   // main sequence
   initial begin
      tick(5);
      chk("ack", ack, 0);
      chk("path_a", pa, 0);
      rst_n <= 1;
      wb(1, ADDR_SETUP_3, {30'h0, CD_PASS});
      wb(1, ADDR_SETUP_1, 32'h3);
      for (int i = 0; i < 8; i++) begin
         wb(1, ADDR_SETUP_3, {30'h0, rows[i][4:3]});
         hv <= rows[i][7];
         sup <= rows[i][6];
         role_hi <= rows[i][5];
         cdp <= rows[i][2];
         tick(12);
         chk("path_a", pa, rows[i][1]);
         chk("path_b", pb, rows[i][0]);
         chk("lo_bias", lob, rows[i] == 8'hD9);
      end
      sup <= 1;
      tick(40);
      chk("startup", scfg, 2'h1);
      wb(1, ADDR_SETUP_4, 32'h5);
      tick(3);
      chk("ilim", ilim, 3'h5);
      wb(0, ADDR_SETUP_4, 32'h0);
      chk("setup_4", q, 32'h5);
      wb(1, ADDR_SETUP_2, 32'h15);
      tick(3);
      chk("gain", gain, 5'h15);
      wb(0, 8'h3C, 32'h0);
      chk("unmapped", q, 32'h0);
      pinv <= 1;
      cfg2 <= 4'hA;
      cfg3 <= 5'h13;
      role_hi <= 1;
      tick(12);
      chk("pin_gain", gain, 5'h1A);
      chk("pin_path_b", pb, 1);
      chk("role_reset", crst, 1);
      pinv <= 0;
      role_hi <= 0;
      tick(40);
      shrt <= 1;
      tick(10);
      chk("conv_reset", crst, 1);
      chk("fault", foe, 1);
      chk("od_low", {fpo, apo}, 2'h0);
      chk("alert", aoe, 1);
      wb(0, ADDR_ERROR_1, 32'h0);
      chk("err_short", q[0], 1);
      shrt <= 0;
      tick(60);
      wb(0, ADDR_ERROR_1, 32'h0);
      wb(0, ADDR_ERROR_1, 32'h0);
      chk("err_clear", q, 32'h0);
      chk("alert_clr", aoe, 0);
      chk("switching", sw, 1);
      ov <= 1;
      tick(10);
      chk("ov_switch", sw, 0);
      chk("ov_fault", foe, 1);
      ov <= 0;
      tick(10);
      chk("ov_resume", sw, 1);
      trip <= 1;
      below <= 1;
      run <= 1;
      tick(45);
      run <= 0;
      trip <= 0;
      below <= 0;
      wb(0, ADDR_ERROR_1, 32'h0);
      chk("err_trips", q[0], 1);
      tick(40);
      t145 <= 1;
      tick(10);
      wb(0, ADDR_ERROR_1, 32'h0);
      chk("err_warn", q[3], 1);
      t145 <= 0;
      t175 <= 1;
      tick(10);
      chk("hot_off", pwr, 0);
      t175 <= 0;
      tick(10);
      chk("still_off", pwr, 0);
      cool <= 1;
      tick(10);
      chk("cooled_on", pwr, 1);
      cool <= 0;
      wb(1, ADDR_SETUP_4, 32'h8);
      hv <= 0;
      tick(12);
      chk("hold_on", pwr, 1);
      tick(40);
      chk("hold_end", pwr, 0);
      rst_n <= 0;
      tick(2);
      chk("rst_gain", gain, 5'h00);
      rst_n <= 1;
      tick(12);
      chk("rst_off", pwr, 0);
      final_report();
   end
endmodule
